// ### psbs_core.sv
`timescale 1ns/100ps
`include "psbs_regs.svh"

module psbs_core (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic [17:0] ADDR,
  input  wire logic        PROCESSOR_ADDRESS_STROBE_N,
  input  wire logic        CONTROLLER_ADDRESS_STROBE_N,
  input  wire logic        BURST_ADVANCE_N,
  input  wire logic        GLOBAL_WRITE_N,
  input  wire logic        BYTE_WRITE_ENABLE_N,
  input  wire logic [1:0]  BYTE_SELECT_N,
  input  wire logic        CHIP_SELECT_ONE_N,
  input  wire logic        CHIP_SELECT_TWO,
  input  wire logic        CHIP_SELECT_THREE_N,
  input  wire logic        OUTPUT_ENABLE_N,
  input  wire logic        BURST_ORDER_SEL,
  input  wire logic        SLEEP_REQUEST,
  input  wire logic [15:0] DQ_IN,
  input  wire logic [1:0]  PARITY_IO_IN,
  output logic      [15:0] DQ_OUT,
  output logic      [1:0]  PARITY_IO_OUT,
  output logic             DQ_OE_N,
  output logic             SLEEP_ACTIVE
);

  localparam int SYNC_N = `PSBS_SLEEP_ENTRY_CYC;

  psbs_pkg::psbs_state_t st_r;
  psbs_pkg::psbs_state_t st_nxt;
  psbs_pkg::psbs_dec_t   dec;
  psbs_pkg::psbs_word_t  din;

  logic [SYNC_N-1:0]              zz_sync_r;
  logic [1:0]                     oe_sync_r;
  logic [1:0]                     mode_sync_r;
  logic [`PSBS_ADDR_W-1:2]        base_r;
  logic [`PSBS_BEAT_W-1:0]        start_r;
  logic [`PSBS_BEAT_W-1:0]        cnt_r;
  logic [`PSBS_BEAT_W-1:0]        cnt_use;
  logic [`PSBS_BEAT_W-1:0]        cnt_nxt;
  logic [`PSBS_BEAT_W-1:0]        addr_lo;
  logic [`PSBS_ADDR_W-1:0]        acc_addr;
  logic [`PSBS_LANES-1:0]         lane_we;
  logic                           dq_oe_n_r;
  logic                           dq_oe_n_nxt;
  logic                           asleep;
  logic                           interleaved;
  logic                           sel;
  logic                           processor_address_strobe_n_act;
  logic                           controller_address_strobe_n_act;
  logic                           new_acc;
  logic                           wr_any;
  logic                           do_write;
  logic                           do_read;

  // Asynchronous sleep request, output enable and strap pass a sync chain
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      zz_sync_r   <= '0;
      oe_sync_r   <= 2'h3;
      mode_sync_r <= 2'h3;
    end
    else
    begin
      zz_sync_r   <= {zz_sync_r[SYNC_N-2:0], SLEEP_REQUEST}; // [R18]
      oe_sync_r   <= {oe_sync_r[0], OUTPUT_ENABLE_N};
      mode_sync_r <= {mode_sync_r[0], BURST_ORDER_SEL};
    end
  end

  assign asleep       = zz_sync_r[SYNC_N-1]; // [R18]
  assign interleaved  = mode_sync_r[1];      // [R16]
  assign SLEEP_ACTIVE = zz_sync_r[SYNC_N-1];

  assign din.dat = DQ_IN;
  assign din.par = PARITY_IO_IN;

  // Strobe and select decode
  assign sel      = !CHIP_SELECT_ONE_N && CHIP_SELECT_TWO && !CHIP_SELECT_THREE_N;
  assign processor_address_strobe_n_act = !PROCESSOR_ADDRESS_STROBE_N && !CHIP_SELECT_ONE_N; // [R11]
  assign controller_address_strobe_n_act = !CONTROLLER_ADDRESS_STROBE_N && !processor_address_strobe_n_act;         // [R11]

  assign dec.processor_address_strobe_n_go  = processor_address_strobe_n_act && sel;                                 // [R1]
  assign dec.controller_address_strobe_n_go  = controller_address_strobe_n_act && sel;                                 // [R9]
  assign dec.desel    = (processor_address_strobe_n_act || controller_address_strobe_n_act) && !sel;
  assign dec.cont     = !processor_address_strobe_n_act && !controller_address_strobe_n_act && (st_r == psbs_pkg::PSBS_ACTIVE);
  assign dec.adv_step = dec.cont && !BURST_ADVANCE_N;                    // [R13]

  assign new_acc = dec.processor_address_strobe_n_go || dec.controller_address_strobe_n_go;

  // Write decode: global write overrides, else enable qualifies selects
  assign lane_we = !GLOBAL_WRITE_N      ? 2'h3 :           // [R4] [R6]
                   !BYTE_WRITE_ENABLE_N ? ~BYTE_SELECT_N : // [R5] [R6]
                   2'h0;
  assign wr_any  = |lane_we;

  // Processor-strobe first cycle never writes; its write lands on a later edge
  assign do_write = !asleep && wr_any && (dec.controller_address_strobe_n_go || dec.cont); // [R2] [R3] [R10] [R22]
  assign do_read  = !asleep && (dec.processor_address_strobe_n_go || (!wr_any && (dec.controller_address_strobe_n_go || dec.cont)));

  // Burst address generation
  assign cnt_use = dec.adv_step ? cnt_r + 2'h1 : cnt_r;          // [R12] [R13]
  assign addr_lo = interleaved ? (start_r ^ cnt_use)             // [R14]
                               : (start_r + cnt_use);            // [R15]
  assign acc_addr = new_acc ? ADDR : {base_r, addr_lo};          // [R1] [R22]
  assign cnt_nxt  = new_acc ? 2'h0 : cnt_use;

  always_comb
  begin
    st_nxt = st_r;
    if (asleep)
    begin
      st_nxt = psbs_pkg::PSBS_ASLEEP; // [R19]
    end
    else if (new_acc)
    begin
      st_nxt = psbs_pkg::PSBS_ACTIVE;
    end
    else if (dec.desel || (st_r == psbs_pkg::PSBS_ASLEEP))
    begin
      st_nxt = psbs_pkg::PSBS_IDLE;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_r <= psbs_pkg::PSBS_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Address register and wraparound counter
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      base_r  <= '0;
      start_r <= 2'h0;
      cnt_r   <= 2'h0;
    end
    else if (!asleep && (new_acc || dec.cont))
    begin
      base_r  <= acc_addr[`PSBS_ADDR_W-1:2]; // [R1] [R9]
      start_r <= new_acc ? ADDR[1:0] : start_r; // [R12]
      cnt_r   <= cnt_nxt;                    // [R12] [R13]
    end
  end

  // Drivers: writes force high impedance; reads drive only with enable low
  assign dq_oe_n_nxt = do_write || !do_read || oe_sync_r[1] || asleep; // [R8]

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dq_oe_n_r <= 1'h1;
    end
    else
    begin
      dq_oe_n_r <= dq_oe_n_nxt; // [R8]
    end
  end

  assign DQ_OE_N = dq_oe_n_r;

  // One storage array per byte lane, each lane holding data and parity
  for (genvar k = 0; k < `PSBS_LANES; k++)
  begin : g_lane
    logic [`PSBS_LANE_W-1:0] lane_mem [`PSBS_DEPTH];
    logic [`PSBS_LANE_W-1:0] rd_r;

    always_ff @(posedge MCLK)
    begin
      if (do_write && lane_we[k])
      begin
        lane_mem[acc_addr] <= {din.par[k], din.dat[8*k +: 8]}; // [R4] [R5] [R10]
      end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        rd_r <= '0;
      end
      else if (do_read)
      begin
        rd_r <= lane_mem[acc_addr];
      end
    end

    assign DQ_OUT[8*k +: 8] = rd_r[7:0];
    assign PARITY_IO_OUT[k] = rd_r[8];
  end

  property p_load_addr;
    @(posedge MCLK) disable iff (!RST_B)
    (dec.processor_address_strobe_n_go && !asleep) |=> (base_r == $past(ADDR[17:2])) && (start_r == $past(ADDR[1:0])) && (cnt_r == 2'h0);
  endproperty
  a_load_addr: assert property (p_load_addr) // [R1]
    else $error("Address not loaded on processor strobe");

  property p_first_no_write;
    @(posedge MCLK) disable iff (!RST_B)
    dec.processor_address_strobe_n_go |-> !do_write && (cnt_use == cnt_r);
  endproperty
  a_first_no_write: assert property (p_first_no_write) // [R2]
    else $error("Write or advance acted on in first cycle");

  property p_second_edge_write;
    @(posedge MCLK) disable iff (!RST_B)
    (dec.processor_address_strobe_n_go && !asleep ##1 !asleep && PROCESSOR_ADDRESS_STROBE_N && CONTROLLER_ADDRESS_STROBE_N
      && BURST_ADVANCE_N && !GLOBAL_WRITE_N) |-> do_write && (acc_addr == $past(ADDR));
  endproperty
  a_second_edge_write: assert property (p_second_edge_write) // [R3]
    else $error("Second-edge write missing or misaddressed");

  property p_global_all;
    @(posedge MCLK) disable iff (!RST_B)
    (do_write && !GLOBAL_WRITE_N) |-> (lane_we == 2'h3);
  endproperty
  a_global_all: assert property (p_global_all) // [R4]
    else $error("Global write did not enable every lane");

  property p_byte_sel;
    @(posedge MCLK) disable iff (!RST_B)
    (GLOBAL_WRITE_N && !BYTE_WRITE_ENABLE_N) |-> (lane_we == ~BYTE_SELECT_N);
  endproperty
  a_byte_sel: assert property (p_byte_sel) // [R5]
    else $error("Byte lanes differ from selects");

  property p_read_decode;
    @(posedge MCLK) disable iff (!RST_B)
    (GLOBAL_WRITE_N && (BYTE_WRITE_ENABLE_N || (BYTE_SELECT_N == 2'h3))) |-> !do_write;
  endproperty
  a_read_decode: assert property (p_read_decode) // [R6]
    else $error("Read combination caused a write");

  property p_write_hiz;
    @(posedge MCLK) disable iff (!RST_B)
    do_write |=> DQ_OE_N;
  endproperty
  a_write_hiz: assert property (p_write_hiz) // [R8]
    else $error("Drivers on after write cycle");

  property p_controller_address_strobe_n_write;
    @(posedge MCLK) disable iff (!RST_B)
    (dec.controller_address_strobe_n_go && wr_any && !asleep) |-> do_write && (acc_addr == ADDR);
  endproperty
  a_controller_address_strobe_n_write: assert property (p_controller_address_strobe_n_write) // [R10]
    else $error("Controller-strobe write not done in its cycle");

  property p_processor_address_strobe_n_priority;
    @(posedge MCLK) disable iff (!RST_B)
    (!PROCESSOR_ADDRESS_STROBE_N && !CONTROLLER_ADDRESS_STROBE_N && !CHIP_SELECT_ONE_N) |-> !dec.controller_address_strobe_n_go;
  endproperty
  a_processor_address_strobe_n_priority: assert property (p_processor_address_strobe_n_priority) // [R11]
    else $error("Controller strobe taken while processor strobe low");

  property p_advance;
    @(posedge MCLK) disable iff (!RST_B)
    (dec.adv_step && !asleep) |=> (cnt_r == $past(cnt_r) + 2'h1) && (start_r == $past(start_r));
  endproperty
  a_advance: assert property (p_advance) // [R13]
    else $error("Burst counter did not step");

  property p_interleave;
    @(posedge MCLK) disable iff (!RST_B)
    (interleaved && dec.cont) |-> (acc_addr[1:0] == (start_r ^ cnt_use));
  endproperty
  a_interleave: assert property (p_interleave) // [R14]
    else $error("Interleaved beat address wrong");

  property p_linear;
    @(posedge MCLK) disable iff (!RST_B)
    (!interleaved && dec.cont && dec.adv_step && (cnt_r == 2'h3)) |-> (acc_addr[1:0] == start_r);
  endproperty
  a_linear: assert property (p_linear) // [R15]
    else $error("Linear order did not wrap");

  property p_sleep_entry;
    @(posedge MCLK) disable iff (!RST_B)
    SLEEP_REQUEST ##1 SLEEP_REQUEST |=> SLEEP_ACTIVE;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) // [R18]
    else $error("Sleep not entered after two cycles");

  property p_sleep_quiet;
    @(posedge MCLK) disable iff (!RST_B)
    SLEEP_ACTIVE |-> !do_write ##1 DQ_OE_N;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) // [R19]
    else $error("Access acted on while asleep");

endmodule : psbs_core

// ### psbs_core_tb.sv
`timescale 1ns/100ps
module psbs_core_tb;
  logic                 clk = 1'h0;
  logic                 rst_b = 1'h0;
  logic          [17:0] addr;
  logic                 processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n, gw_n, bwe_n, oe_n, mode, zz;
  logic          [1:0]  bs_n;
  logic          [2:0]  cs;
  psbs_pkg::psbs_word_t wd;
  logic          [15:0] dq_o;
  logic          [1:0]  par_o;
  logic                 oe_o_n;
  logic                 slp;
  int                   num_errors = 0;
  int                   n_tests = 0;
  int                   seed = 32'h309e;
  psbs_pkg::psbs_word_t mem [int];

  always #2 clk = ~clk;

  psbs_master i_master (.clk(clk), .addr(addr), .processor_address_strobe_n_n(processor_address_strobe_n_n), .controller_address_strobe_n_n(controller_address_strobe_n_n), .adv_n(adv_n),
    .gw_n(gw_n), .bwe_n(bwe_n), .bs_n(bs_n), .cs(cs), .oe_n(oe_n), .mode(mode), .zz(zz), .wd(wd));

  psbs_core i_dut (.MCLK(clk), .RST_B(rst_b), .ADDR(addr), .PROCESSOR_ADDRESS_STROBE_N(processor_address_strobe_n_n),
    .CONTROLLER_ADDRESS_STROBE_N(controller_address_strobe_n_n), .BURST_ADVANCE_N(adv_n), .GLOBAL_WRITE_N(gw_n),
    .BYTE_WRITE_ENABLE_N(bwe_n), .BYTE_SELECT_N(bs_n), .CHIP_SELECT_ONE_N(cs[2]),
    .CHIP_SELECT_TWO(cs[1]), .CHIP_SELECT_THREE_N(cs[0]), .OUTPUT_ENABLE_N(oe_n),
    .BURST_ORDER_SEL(mode), .SLEEP_REQUEST(zz), .DQ_IN(wd.dat), .PARITY_IO_IN(wd.par),
    .DQ_OUT(dq_o), .PARITY_IO_OUT(par_o), .DQ_OE_N(oe_o_n), .SLEEP_ACTIVE(slp));

  function automatic logic [17:0] ra();
    return 18'($random(seed));
  endfunction : ra

  function automatic psbs_pkg::psbs_word_t rw();
    return 18'($random(seed));
  endfunction : rw

  // Lane k kept unless global write or byte enable with its select low
  function automatic psbs_pkg::psbs_word_t mg(input psbs_pkg::psbs_word_t o, w, input logic [3:0] q);
    for (int k = 0; k < 2; k++)
    begin
      if (!q[3] || (!q[2] && !q[k]))
      begin
        o.par[k] = w.par[k];
        o.dat[k*8 +: 8] = w.dat[k*8 +: 8];
      end
    end
    return o;
  endfunction : mg

  function automatic logic [17:0] bt(input logic [17:0] a, input logic [1:0] n, input logic m);
    return {a[17:2], m ? a[1:0] ^ n : a[1:0] + n};
  endfunction : bt

  task automatic chk(input string nm, input logic [17:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic idle();
    i_master.cyc(7'h7f, ra(), rw());
  endtask : idle

  task automatic cw(input logic [17:0] a, input logic [3:0] q, input psbs_pkg::psbs_word_t w);
    i_master.cyc({3'h4, q}, a, w);
    mem[a] = mg(mem[a], w, q);
  endtask : cw

  // Both strobes low with write inputs low: must start a plain read
  task automatic rd(input logic [17:0] a);
    repeat (3) idle();
    i_master.cyc(7'h00, a, rw());
    idle();
    idle();
    chk("read data", mem[a], {par_o, dq_o});
    chk("output enable", 18'h0_0000, {17'h0_0000, oe_o_n});
  endtask : rd

  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    logic [17:0] a;
    logic [3:0]  q;
    psbs_pkg::psbs_word_t w;
    repeat (3) @(negedge clk);
    rst_b = 1'h1;
    repeat (2) idle();
    for (int m = 1; m >= 0; m--)
    begin
      // The order strap only changes across a reset
      i_master.mode = m[0];
      rst_b = 1'h0;
      @(negedge clk);
      rst_b = 1'h1;
      repeat (4) idle();
      for (int i = 0; i < 3; i++)
      begin
        a = ra();
        for (int n = 0; n < 4; n++)
          cw(bt(a, n[1:0], m[0]), 4'h0, rw());
        i_master.cyc(7'h20, a, rw());
        for (int n = 0; n < 4; n++)
        begin
          w = rw();
          q = 4'($random(seed));
          i_master.cyc({2'h3, (n == 0), q}, ra(), w);
          mem[bt(a, n[1:0], m[0])] = mg(mem[bt(a, n[1:0], m[0])], w, q);
        end
        for (int n = 0; n < 4; n++)
          rd(bt(a, n[1:0], m[0]));
      end
    end
    for (int i = 0; i < 24; i++)
    begin
      a = ra();
      cw(a, 4'h0, rw());
      cw(a, i < 16 ? i[3:0] : 4'($random(seed)), rw());
      rd(a);
    end
    i_master.cs = 3'h6;
    i_master.cyc(7'h00, a, rw());
    idle();
    i_master.cs = 3'h2;
    rd(a);
    i_master.rude = 1'h1;
    repeat (3) idle();
    cw(a, 4'h3, rw());
    idle();
    chk("drivers off", 18'h0_0001, {17'h0_0000, oe_o_n});
    i_master.rude = 1'h0;
    rd(a);
    i_master.doze(1'h1);
    @(negedge clk);
    chk("sleep entry", 18'h0_0000, {17'h0_0000, slp});
    chk("deselect drivers", 18'h0_0001, {17'h0_0000, oe_o_n});
    @(negedge clk);
    chk("sleep entry", 18'h0_0001, {17'h0_0000, slp});
    repeat (4) @(negedge clk);
    i_master.doze(1'h0);
    chk("sleep exit", 18'h0_0000, {17'h0_0000, slp});
    i_master.cs = 3'h2;
    rd(a);
    tally_and_finish();
  end
endmodule : psbs_core_tb

// ### psbs_master.sv
`timescale 1ns/100ps
module psbs_master (
  input  wire logic            clk,
  output logic          [17:0] addr,
  output logic                 processor_address_strobe_n_n,
  output logic                 controller_address_strobe_n_n,
  output logic                 adv_n,
  output logic                 gw_n,
  output logic                 bwe_n,
  output logic          [1:0]  bs_n,
  output logic          [2:0]  cs,
  output logic                 oe_n,
  output logic                 mode,
  output logic                 zz,
  output psbs_pkg::psbs_word_t wd
);
  logic rude;

  initial
  begin
    {processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n, gw_n, bwe_n, bs_n} = 7'h7f;
    addr = 18'h0_0000;
    cs = 3'h2;
    oe_n = 1'h0;
    mode = 1'h1;
    zz = 1'h0;
    wd = '0;
    rude = 1'h0;
  end

  // One bus cycle; k packs both strobes, advance, global, byte enable, selects
  task automatic cyc(input logic [6:0] k, input logic [17:0] a, input psbs_pkg::psbs_word_t w);
    logic wr;
    @(negedge clk);
    wr = k[6] && (!k[3] || (!k[2] && k[1:0] != 2'h3));
    {processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n, gw_n, bwe_n, bs_n} = k;
    addr = a;
    oe_n = wr && !rude;
    wd = wr ? w : ~wd;
  endtask : cyc

  task automatic doze(input logic on);
    @(negedge clk);
    // Controller strobe with select one high is a real deselect
    cs = 3'h5;
    {processor_address_strobe_n_n, controller_address_strobe_n_n} = {1'h1, !on};
    @(negedge clk);
    controller_address_strobe_n_n = 1'h1;
    zz = on;
    if (!on)
      repeat (2) @(negedge clk);
  endtask : doze
endmodule : psbs_master

// ### psbs_pkg.sv
package psbs_pkg;

  typedef enum logic [1:0] {
    PSBS_IDLE,
    PSBS_ACTIVE,
    PSBS_ASLEEP
  } psbs_state_t;

  typedef struct packed {
    logic [1:0]  par;
    logic [15:0] dat;
  } psbs_word_t;

  typedef struct packed {
    logic processor_address_strobe_n_go;
    logic controller_address_strobe_n_go;
    logic desel;
    logic cont;
    logic adv_step;
  } psbs_dec_t;

endpackage : psbs_pkg

// ### psbs_regs.svh
// What this block does, and what its master and board must do (R7, R17, R20, R21)
// R1: Processor strobe with selects loads full address
// R2: First processor-strobe cycle ignores write and advance
// R3: Processor-strobe write takes data at second edge
// R4: Global write stores all data and parity
// R5: Byte write stores only selected bytes
// R6: Decode global, byte enable and byte selects
// R7: Master raises output enable before driving data
// R8: Any write cycle turns data drivers off
// R9: Controller strobe write loads address when selected
// R10: Controller-strobe write completes in one cycle
// R11: Processor strobe wins; ignored when select one high
// R12: Two-bit wraparound counter loaded from low address
// R13: Low advance steps counter in read and write
// R14: Interleaved order XORs start with beat index
// R15: Linear order counts up modulo four
// R16: Burst-order select input picks the order
// R17: Burst-order select is strapped and kept static
// R18: Sleep request enters and exits in two cycles
// R19: Sleep keeps data; pending accesses are dropped
// R20: Master deselects before requesting sleep
// R21: Selects and strobes idle two cycles after wake
// R22: Burst write beats take data at same edge
`ifndef PSBS_REGS_SVH
`define PSBS_REGS_SVH

`define PSBS_ADDR_W          18
`define PSBS_DEPTH           262144
`define PSBS_LANES           2
`define PSBS_LANE_W          9
`define PSBS_BEAT_W          2
`define PSBS_CLK_PERIOD_NS   4
`define PSBS_SLEEP_ENTRY_NS  (2 * `PSBS_CLK_PERIOD_NS)
`define PSBS_SLEEP_ENTRY_CYC (`PSBS_SLEEP_ENTRY_NS / `PSBS_CLK_PERIOD_NS)
`define PSBS_SLEEP_RECOVERY_NS (2 * `PSBS_CLK_PERIOD_NS)

`endif
